// *** bgtt_pkg.sv ***
// shared constants, types and helpers for the bank-group turnaround timing link
package bgtt_pkg;
    // ************************************************************
    // clocks
    // ************************************************************
    localparam int SYS_PERIOD_PS = 4000;
    localparam int LINK_HALF_DIV = 3;
    localparam int LINK_PERIOD_PS = 2 * LINK_HALF_DIV * SYS_PERIOD_PS;

    // ************************************************************
    // geometry and link fields
    // ************************************************************
    localparam int BG_COUNT = 4;
    localparam int BG_W = 2;
    localparam int BA_W = 2;
    localparam int DATA_W = 8;
    localparam int GAP_W = 6;
    typedef logic [GAP_W-1:0] bgtt_gap_t;
    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_ACT = 2'h1,
        CMD_RD = 2'h2,
        CMD_WR = 2'h3
    } bgtt_cmd_e;

    // burst-length field of mode_config_zero
    localparam logic [1:0] BURST_FIXED8 = 2'h0;
    localparam logic [1:0] BURST_OTF = 2'h1;
    localparam logic [1:0] BURST_CHOP4 = 2'h2;
    localparam logic [3:0] EIGHT_BEAT_BURST = 4'h8;
    localparam logic [3:0] FOUR_BEAT_CHOP = 4'h4;

    // ************************************************************
    // timing: clock minimum and time minimum of each gap
    // ************************************************************
    localparam int ACT_TO_ACT_SHORT_NCK = 4;
    localparam int ACT_TO_ACT_SHORT_PS = 5000;
    localparam int ACT_TO_ACT_LONG_NCK = 4;
    localparam int ACT_TO_ACT_LONG_PS = 6000;
    localparam int COL_TO_COL_SHORT_NCK = 4;
    localparam int COL_TO_COL_SHORT_PS = 0;
    localparam int COL_TO_COL_LONG_NCK = 4;
    localparam int COL_TO_COL_LONG_PS = 6250;
    localparam int WR_TO_RD_SHORT_NCK = 2;
    localparam int WR_TO_RD_SHORT_PS = 2500;
    localparam int WR_TO_RD_LONG_NCK = 4;
    localparam int WR_TO_RD_LONG_PS = 7500;
    localparam int CAS_READ_LATENCY = 11;
    localparam int CAS_WRITE_LATENCY = 9;
    localparam int WRITE_PREAMBLE_LEN = 1;
    // extended initial impedance calibration, in link clocks
    localparam int INITIAL_IMPEDANCE_CAL_NCK = 1024;

    // larger of clock count and time rounded up to link clocks
    function automatic bgtt_gap_t bgtt_gap(input int nck, input int ps);
        int fromTime;
        fromTime = (ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
        return GAP_W'((nck > fromTime) ? nck : fromTime);
    endfunction

    localparam bgtt_gap_t ACT_TO_ACT_SHORT_GAP = bgtt_gap(ACT_TO_ACT_SHORT_NCK, ACT_TO_ACT_SHORT_PS);
    localparam bgtt_gap_t ACT_TO_ACT_LONG_GAP = bgtt_gap(ACT_TO_ACT_LONG_NCK, ACT_TO_ACT_LONG_PS);
    localparam bgtt_gap_t COL_TO_COL_SHORT_GAP = bgtt_gap(COL_TO_COL_SHORT_NCK, COL_TO_COL_SHORT_PS);
    localparam bgtt_gap_t COL_TO_COL_LONG_GAP = bgtt_gap(COL_TO_COL_LONG_NCK, COL_TO_COL_LONG_PS);
    localparam bgtt_gap_t WR_TO_RD_SHORT_GAP = bgtt_gap(WR_TO_RD_SHORT_NCK, WR_TO_RD_SHORT_PS);
    localparam bgtt_gap_t WR_TO_RD_LONG_GAP = bgtt_gap(WR_TO_RD_LONG_NCK, WR_TO_RD_LONG_PS);

    // read burst term: 8 for fixed 8 or on-the-fly with select high
    function automatic logic [3:0] bgtt_read_len(input logic [1:0] mode, input logic sel);
        return ((mode == BURST_FIXED8) || ((mode == BURST_OTF) && sel)) ? EIGHT_BEAT_BURST : FOUR_BEAT_CHOP;
    endfunction

    // write burst term: 4 only when chop is fixed by configuration
    function automatic logic [3:0] bgtt_write_len(input logic [1:0] mode);
        return (mode == BURST_CHOP4) ? FOUR_BEAT_CHOP : EIGHT_BEAT_BURST;
    endfunction

    function automatic bgtt_gap_t bgtt_dec(input bgtt_gap_t v);
        return (v == '0) ? '0 : bgtt_gap_t'(v - 1'b1);
    endfunction

    // ************************************************************
    // wishbone register map of the controller
    // ************************************************************
    localparam int WB_AW = 4;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_CFG = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'hC;
    localparam int CMD_KIND_LSB = 0;
    localparam int CMD_BG_LSB = 2;
    localparam int CMD_BA_LSB = 4;
    localparam int CMD_SEL_BIT = 6;
    localparam int CMD_DATA_LSB = 8;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam int STAT_CAL_DONE_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_RSP_BIT = 2;
    localparam int STAT_INFLIGHT_LSB = 3;
    localparam int RDATA_VALID_BIT = 8;
endpackage

// *** bgtt_link_if.sv ***
// command/address and data link between controller and memory device
`timescale 1ns/1ps
interface bgtt_link_if;
    import bgtt_pkg::*;
    logic linkClk;
    bgtt_cmd_e cmd;
    logic [BG_W-1:0] bankGroupSelect;
    logic [BA_W-1:0] bank;
    logic burstSelectAddrBit;
    logic [DATA_W-1:0] wrData;
    logic [DATA_W-1:0] rdData;
    logic rdToggle;
    modport ctrl(
        output linkClk, cmd, bankGroupSelect, bank, burstSelectAddrBit, wrData,
        input rdData, rdToggle
    );
    modport dram(
        input linkClk, cmd, bankGroupSelect, bank, burstSelectAddrBit, wrData,
        output rdData, rdToggle
    );
endinterface

// *** bgtt_dram.sv ***
// memory device end: samples the link, stores words, answers reads
`timescale 1ns/1ps
module bgtt_dram #(
    parameter int CAL_INIT_NCK = bgtt_pkg::INITIAL_IMPEDANCE_CAL_NCK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [1:0] modeConfigZero,
    input wire logic dllLocked,
    output logic calDone,
    output logic [3:0] burstLen,
    output logic calFault,
    output logic lockFault,
    bgtt_link_if.dram lnk
);
    import bgtt_pkg::*;

    localparam int BUS_W = 2 + BG_W + BA_W + 1 + DATA_W;
    localparam int CAL_W = $clog2(CAL_INIT_NCK + 1);

    // ************************************************************
    // synchronisers: link clock, command bundle, lock level
    // ************************************************************
    logic ckS1_r, ckS2_r, ckS3_r;
    logic [BUS_W-1:0] busS1_r, busS2_r;
    logic dllS1_r, dllS2_r;
    logic [CAL_W-1:0] calCnt_r;
    logic [DATA_W-1:0] mem_r [BG_COUNT * 4];

    // all sampled together, so the bundle is settled when the edge shows
    always_ff @(posedge sys_clk) begin
        ckS1_r <= lnk.linkClk;
        ckS2_r <= ckS1_r;
        ckS3_r <= ckS2_r;
        busS1_r <= {lnk.cmd, lnk.bankGroupSelect, lnk.bank, lnk.burstSelectAddrBit, lnk.wrData};
        busS2_r <= busS1_r;
        dllS1_r <= dllLocked;
        dllS2_r <= dllS1_r;
    end

    // ************************************************************
    // decode of the sampled command at each link rising edge
    // ************************************************************
    wire linkEdge = ckS2_r && !ckS3_r;
    wire [1:0] cmdKind = busS2_r[BUS_W-1 -: 2];
    wire [BG_W+BA_W-1:0] bankAddr = busS2_r[DATA_W+1 +: BG_W+BA_W];
    wire sampledSel = busS2_r[DATA_W];
    wire [DATA_W-1:0] sampledData = busS2_r[DATA_W-1:0];
    wire cmdSeen = linkEdge && (cmdKind != CMD_NOP);
    wire doRead = cmdSeen && calDone && (cmdKind == CMD_RD);
    wire doWrite = cmdSeen && calDone && (cmdKind == CMD_WR);

    // storage array, no reset: contents are undefined until written
    always_ff @(posedge sys_clk) begin
        if (doWrite) begin
            mem_r[bankAddr] <= sampledData;
        end
    end

    // calibration window, read answers and burst reporting
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            calCnt_r <= '0;
            calDone <= 1'b0;
            calFault <= 1'b0;
            lockFault <= 1'b0;
            burstLen <= EIGHT_BEAT_BURST;
            lnk.rdData <= '0;
            lnk.rdToggle <= 1'b0;
        end else begin
            if (linkEdge && !calDone) begin
                calCnt_r <= calCnt_r + 1'b1;
                calDone <= (calCnt_r == CAL_W'(CAL_INIT_NCK - 1));
            end
            if (cmdSeen && !calDone) begin
                calFault <= 1'b1; // commands inside calibration are dropped
            end
            if (doRead) begin
                lnk.rdData <= mem_r[bankAddr];
                lnk.rdToggle <= !lnk.rdToggle;
                burstLen <= bgtt_read_len(modeConfigZero, sampledSel);
                if (!dllS2_r) begin
                    lockFault <= 1'b1; // strobe timing only holds with loop locked
                end
            end
            if (doWrite) begin
                burstLen <= bgtt_write_len(modeConfigZero);
            end
        end
    end
endmodule

// *** bgtt_ctrl.sv ***
// memory controller end: wishbone registers, spacing timers and link driver
// Functional notes
// - activates to different groups need short gap
// - activates within one group need long gap
// - write then other-group read waits short delay
// - write then same-group read waits long delay
// - read-to-write spacing from latencies, burst, preamble
// - write-to-read spacing from latency, burst, delay
// - read term 8, or 4 when chopped
// - write term 4 only for fixed chop
// - extended calibration times precede command traffic
// - read strobe timing needs locked delay loop; reads still issue unlocked, the device only sets lockFault
// - eight beats: field 00, or 01 with select
// - column commands spaced short or long by group
// - gap is larger of clocks and time
`timescale 1ns/1ps
module bgtt_ctrl #(
    parameter int CAL_INIT_NCK = bgtt_pkg::INITIAL_IMPEDANCE_CAL_NCK
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [bgtt_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    bgtt_link_if.ctrl lnk
);
    import bgtt_pkg::*;

    typedef enum logic [1:0] {
        ST_CAL = 2'b01,
        ST_RUN = 2'b10
    } bgtt_state_e;

    localparam int CAL_W = $clog2(CAL_INIT_NCK + 1);

    // ************************************************************
    // link clock divider
    // ************************************************************
    logic [2:0] divCnt_r;
    logic linkClk_r;
    wire divWrap = (divCnt_r == 3'(LINK_HALF_DIV - 1));
    // commands change on the falling link edge so they are stable at the rise
    wire fallTick = divWrap && linkClk_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt_r <= '0;
            linkClk_r <= 1'b0;
        end else begin
            divCnt_r <= divWrap ? 3'h0 : 3'(divCnt_r + 1'b1);
            if (divWrap) begin
                linkClk_r <= !linkClk_r;
            end
        end
    end
    assign lnk.linkClk = linkClk_r;

    // ************************************************************
    // calibration wait after reset
    // ************************************************************
    bgtt_state_e state_r;
    logic [CAL_W-1:0] calCnt_r;
    wire calEnd = fallTick && (calCnt_r == CAL_W'(CAL_INIT_NCK - 1));

    // no command leaves before the extended initial calibration has run
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= ST_CAL;
            calCnt_r <= '0;
        end else begin
            case (state_r)
                ST_CAL: begin
                    if (fallTick) begin
                        calCnt_r <= calCnt_r + 1'b1;
                    end
                    if (calEnd) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
                default: begin
                    state_r <= ST_CAL;
                end
            endcase
        end
    end

    // ************************************************************
    // wishbone slave
    // ************************************************************
    logic [1:0] cfgMode_r;
    logic holdValid_r;
    bgtt_cmd_e hKind_r;
    logic [BG_W-1:0] hBg_r;
    logic [BA_W-1:0] hBa_r;
    logic hSel_r;
    logic [DATA_W-1:0] hData_r;
    logic v0_r, v1_r;
    logic [DATA_W-1:0] d0_r, d1_r;
    logic [1:0] inflight_r;
    logic [31:0] rdMux;

    wire wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire selCmd = (wb_adr_i == REG_CMD);
    wire selCfg = (wb_adr_i == REG_CFG);
    wire selStat = (wb_adr_i == REG_STATUS);
    wire selRdata = (wb_adr_i == REG_RDATA);
    wire cmdWrite = wbReq && wb_we_i && selCmd && wb_sel_i[0] && wb_sel_i[1];
    // a command write waits in wait states while the hold slot is full
    wire wbTake = wbReq && !(cmdWrite && holdValid_r);
    wire loadHold = wbTake && cmdWrite;
    wire cfgWrite = wbTake && wb_we_i && selCfg && wb_sel_i[0];
    wire popRsp = wbTake && !wb_we_i && selRdata && v0_r;

    assign rdMux = selCfg ? {30'h0, cfgMode_r} :
                   selStat ? {27'h0, inflight_r, v0_r, holdValid_r, (state_r == ST_RUN)} :
                   selRdata ? {23'h0, v0_r, d0_r} : 32'h0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            cfgMode_r <= CFG_RESET;
        end else begin
            wb_ack_o <= wbTake;
            wb_dat_o <= wbTake ? rdMux : 32'h0;
            if (cfgWrite) begin
                cfgMode_r <= wb_dat_i[1:0];
            end
        end
    end

    // ************************************************************
    // spacing checks against the running timers
    // ************************************************************
    bgtt_gap_t actAll_r, colAll_r, wrRdAll_r, rdWr_r;
    bgtt_gap_t actBg_r [BG_COUNT];
    bgtt_gap_t colBg_r [BG_COUNT];
    bgtt_gap_t wrRdBg_r [BG_COUNT];

    wire isAct = (hKind_r == CMD_ACT);
    wire isRd = (hKind_r == CMD_RD);
    wire isWr = (hKind_r == CMD_WR);
    wire [2:0] bufCount = 3'(v0_r) + 3'(v1_r);
    // reads are issued only while the buffer can take every answer
    wire rdRoom = (3'(inflight_r) + bufCount) < 3'h2;
    wire actOk = (actAll_r == '0) && (actBg_r[hBg_r] == '0);
    wire colOk = (colAll_r == '0) && (colBg_r[hBg_r] == '0);
    wire rdOk = colOk && (wrRdAll_r == '0) && (wrRdBg_r[hBg_r] == '0) && rdRoom;
    wire wrOk = colOk && (rdWr_r == '0);
    wire kindOk = (isAct && actOk) || (isRd && rdOk) || (isWr && wrOk) || (hKind_r == CMD_NOP);
    wire issue = fallTick && (state_r == ST_RUN) && holdValid_r && kindOk;

    // burst terms from the very command being issued
    wire [3:0] read_burst_len = bgtt_read_len(cfgMode_r, hSel_r);
    wire [3:0] write_burst_len = bgtt_write_len(cfgMode_r);
    // load values hold one less than the gap: the issuing edge is the first
    wire bgtt_gap_t gapRdWr = bgtt_gap_t'(CAS_READ_LATENCY - CAS_WRITE_LATENCY + WRITE_PREAMBLE_LEN)
                            + bgtt_gap_t'(read_burst_len[3:1]);
    wire bgtt_gap_t gapWrRdS = bgtt_gap_t'(CAS_WRITE_LATENCY - 1) + bgtt_gap_t'(write_burst_len[3:1])
                             + WR_TO_RD_SHORT_GAP;
    wire bgtt_gap_t gapWrRdL = bgtt_gap_t'(CAS_WRITE_LATENCY - 1) + bgtt_gap_t'(write_burst_len[3:1])
                             + WR_TO_RD_LONG_GAP;

    // ************************************************************
    // timers shared by every bank group
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            actAll_r <= '0;
            colAll_r <= '0;
            wrRdAll_r <= '0;
            rdWr_r <= '0;
        end else if (fallTick) begin
            actAll_r <= (issue && isAct) ? bgtt_gap_t'(ACT_TO_ACT_SHORT_GAP - 1) : bgtt_dec(actAll_r);
            colAll_r <= (issue && (isRd || isWr)) ? bgtt_gap_t'(COL_TO_COL_SHORT_GAP - 1)
                        : bgtt_dec(colAll_r);
            wrRdAll_r <= (issue && isWr) ? gapWrRdS : bgtt_dec(wrRdAll_r);
            rdWr_r <= (issue && isRd) ? gapRdWr : bgtt_dec(rdWr_r);
        end
    end

    // ************************************************************
    // timers kept per bank group
    // ************************************************************
    for (genvar g = 0; g < BG_COUNT; g++) begin : gBg
        wire hit = issue && (hBg_r == BG_W'(g));
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                actBg_r[g] <= '0;
                colBg_r[g] <= '0;
                wrRdBg_r[g] <= '0;
            end else if (fallTick) begin
                actBg_r[g] <= (hit && isAct) ? bgtt_gap_t'(ACT_TO_ACT_LONG_GAP - 1)
                              : bgtt_dec(actBg_r[g]);
                colBg_r[g] <= (hit && (isRd || isWr)) ? bgtt_gap_t'(COL_TO_COL_LONG_GAP - 1)
                              : bgtt_dec(colBg_r[g]);
                wrRdBg_r[g] <= (hit && isWr) ? gapWrRdL : bgtt_dec(wrRdBg_r[g]);
            end
        end
    end

    // ************************************************************
    // hold slot and link command driver
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            holdValid_r <= 1'b0;
            hKind_r <= CMD_NOP;
            hBg_r <= '0;
            hBa_r <= '0;
            hSel_r <= 1'b0;
            hData_r <= '0;
            lnk.cmd <= CMD_NOP;
            lnk.bankGroupSelect <= '0;
            lnk.bank <= '0;
            lnk.burstSelectAddrBit <= 1'b0;
            lnk.wrData <= '0;
        end else begin
            if (loadHold) begin
                holdValid_r <= 1'b1;
                hKind_r <= bgtt_cmd_e'(wb_dat_i[CMD_KIND_LSB +: 2]);
                hBg_r <= wb_dat_i[CMD_BG_LSB +: BG_W];
                hBa_r <= wb_dat_i[CMD_BA_LSB +: BA_W];
                hSel_r <= wb_dat_i[CMD_SEL_BIT];
                hData_r <= wb_dat_i[CMD_DATA_LSB +: DATA_W];
            end else if (issue) begin
                holdValid_r <= 1'b0;
            end
            if (fallTick) begin
                lnk.cmd <= issue ? hKind_r : CMD_NOP;
            end
            if (issue) begin
                lnk.bankGroupSelect <= hBg_r;
                lnk.bank <= hBa_r;
                lnk.burstSelectAddrBit <= hSel_r;
                lnk.wrData <= hData_r;
            end
        end
    end

    // ************************************************************
    // read answer sync and two-entry buffer
    // ************************************************************
    logic tog1_r, tog2_r, tog3_r, tog4_r;
    logic [DATA_W-1:0] dat1_r, dat2_r;
    // the toggle is judged one stage later than the data, so the word is settled
    wire push = tog3_r ^ tog4_r;

    always_ff @(posedge sys_clk) begin
        tog1_r <= lnk.rdToggle;
        tog2_r <= tog1_r;
        tog3_r <= tog2_r;
        tog4_r <= tog3_r;
        dat1_r <= lnk.rdData;
        dat2_r <= dat1_r;
    end

    // slot 0 is the head seen by software; slot 1 catches a word during a stall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            v0_r <= 1'b0;
            v1_r <= 1'b0;
            d0_r <= '0;
            d1_r <= '0;
            inflight_r <= '0;
        end else begin
            inflight_r <= 2'(inflight_r + 2'(issue && isRd) - 2'(push));
            if (popRsp) begin
                v0_r <= v1_r || push;
                d0_r <= v1_r ? d1_r : dat2_r;
                v1_r <= v1_r && push;
                if (v1_r && push) begin
                    d1_r <= dat2_r;
                end
            end else if (push && !v0_r) begin
                v0_r <= 1'b1;
                d0_r <= dat2_r;
            end else if (push) begin
                v1_r <= 1'b1;
                d1_r <= dat2_r;
            end
        end
    end
endmodule

// *** bgtt_link_asserts.sv ***
// link checker: clock shape, command hold and command spacing
`timescale 1ns/1ps
module bgtt_link_asserts #(
    parameter int CAL_INIT_NCK = 4
) (
    input logic sys_clk,
    input logic rst,
    input logic linkClk,
    input bgtt_pkg::bgtt_cmd_e cmd,
    input logic [bgtt_pkg::BG_W-1:0] bankGroupSelect,
    input logic [bgtt_pkg::BA_W-1:0] bank,
    input logic [1:0] modeConfigZero,
    input logic burstSelectAddrBit
);
    import bgtt_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // helper: link periods since each command kind
    // ****************************************
    logic clk_r;
    logic [7:0] calCnt_r;
    logic [7:0] actCnt_r;
    logic [7:0] colCnt_r;
    logic [7:0] rdCnt_r;
    logic [7:0] wrCnt_r;
    logic [1:0] wrBg_r;
    logic [7:0] rdHalf_r;
    // saturate so long idle stretches never wrap into a false short gap
    function automatic logic [7:0] sat(input logic [7:0] v);
        return (v == 8'hFF) ? v : v + 8'h01;
    endfunction
    // commands leave at link clock falls, so issue is judged there
    wire fallTick = clk_r & ~linkClk;
    wire issue = fallTick && (cmd != CMD_NOP);
    wire isAct = issue && (cmd == CMD_ACT);
    wire isRd = issue && (cmd == CMD_RD);
    wire isWr = issue && (cmd == CMD_WR);
    // counters restart at 1 on their command, so the value is the gap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clk_r <= 1'b0;
            calCnt_r <= 8'h00;
            actCnt_r <= 8'hFF;
            colCnt_r <= 8'hFF;
            rdCnt_r <= 8'hFF;
            wrCnt_r <= 8'hFF;
            wrBg_r <= 2'h0;
            rdHalf_r <= 8'h04;
        end else begin
            clk_r <= linkClk;
            if (fallTick) begin
                calCnt_r <= sat(calCnt_r);
                actCnt_r <= isAct ? 8'h01 : sat(actCnt_r);
                colCnt_r <= (isRd || isWr) ? 8'h01 : sat(colCnt_r);
                rdCnt_r <= isRd ? 8'h01 : sat(rdCnt_r);
                wrCnt_r <= isWr ? 8'h01 : sat(wrCnt_r);
            end
            if (isWr) wrBg_r <= bankGroupSelect;
            // half the read burst: a chopped read shortens the read to write gap
            if (isRd) rdHalf_r <= ((modeConfigZero == BURST_OTF) ? burstSelectAddrBit
                : (modeConfigZero == BURST_FIXED8)) ? 8'h04 : 8'h02;
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    clk_shape_a: assert property ($rose(linkClk) |-> linkClk[*3] ##1 !linkClk)
        else $error("link clock high time is not three cycles");
    cmd_hold_a: assert property (issue |=> $stable({cmd, bankGroupSelect, bank})[*5])
        else $error("command fields not held one link period");
    cmd_edge_a: assert property ($changed(cmd) |-> fallTick)
        else $error("command changed away from a link clock fall");
    cal_wait_a: assert property (issue |-> calCnt_r >= CAL_INIT_NCK - 1)
        else $error("command issued inside calibration window");
    act_gap_a: assert property (isAct |-> actCnt_r >= 8'h04)
        else $error("activate spacing too short");
    col_gap_a: assert property ((isRd || isWr) |-> colCnt_r >= 8'h04)
        else $error("column command spacing too short");
    rd_wr_gap_a: assert property (isWr |-> rdCnt_r >= 8'h04 + rdHalf_r)
        else $error("read to write spacing too short");
    wr_rd_short_a: assert property (isRd |-> wrCnt_r >= 8'h0D)
        else $error("write to read spacing too short");
    wr_rd_long_a: assert property (isRd && bankGroupSelect == wrBg_r |-> wrCnt_r >= 8'h0F)
        else $error("same group write to read spacing too short");
endmodule

// *** bank_group_turnaround_timing_bench.sv ***
// bench: both link ends joined, driven over wishbone
`timescale 1ns/1ps
module bank_group_turnaround_timing_bench;
    import bgtt_pkg::*;
    localparam int CAL = 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [1:0] modeCfg = 2'h0;
    logic dllLocked = 1'b1;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic [3:0] burstLen;
    logic calDone;
    logic calFault;
    logic lockFault;
    logic [3:0] rdExp;
    logic [3:0] wrExp;
    int num_errors = 0;
    int n_checks = 0;
    bgtt_link_if lnk();
    always #2 sys_clk = ~sys_clk;
    bgtt_ctrl #(.CAL_INIT_NCK(CAL)) bgtt_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .lnk(lnk.ctrl));
    bgtt_dram #(.CAL_INIT_NCK(CAL)) bgtt_dram_inst (.sys_clk(sys_clk), .rst(rst), .modeConfigZero(modeCfg),
        .dllLocked(dllLocked), .calDone(calDone), .burstLen(burstLen), .calFault(calFault),
        .lockFault(lockFault), .lnk(lnk.dram));
    bgtt_link_asserts #(.CAL_INIT_NCK(CAL)) bgtt_link_asserts_inst (.sys_clk(sys_clk), .rst(rst),
        .linkClk(lnk.linkClk), .cmd(lnk.cmd), .bankGroupSelect(lnk.bankGroupSelect), .bank(lnk.bank),
        .modeConfigZero(modeCfg), .burstSelectAddrBit(lnk.burstSelectAddrBit));
    // ****************************************
    // tasks
    // ****************************************
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask
    // one classic cycle; a held command write may take many link periods
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 4000);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 4000) begin
            num_errors++;
            summarize();
        end
    endtask
    // read a register until one bit shows the wanted level
    task poll(input logic [3:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            wb(1'b0, a, 32'h0);
            n++;
        end while (q[b] !== v && n < 500);
        if (n >= 500) begin
            num_errors++;
            summarize();
        end
    endtask
    // the settle wait covers link rise plus device sampling delay
    task send(input bgtt_cmd_e k, input logic [1:0] g, input logic [1:0] b, input logic s, input logic [7:0] d);
        wb(1'b1, REG_CMD, {16'h0, d, 1'b0, s, b, g, k});
        poll(REG_STATUS, STAT_HOLD_BIT, 1'b0);
        repeat (12) @(posedge sys_clk);
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        wb(1'b0, REG_CFG, 32'h0);
        cmp(q, 32'h0);
        wb(1'b0, 4'h2, 32'h0);
        cmp(q, 32'h0);
        poll(REG_STATUS, STAT_CAL_DONE_BIT, 1'b1);
        cmp({31'h0, calDone}, 32'h1);
        $display("test registers done");
        send(CMD_WR, 2'h2, 2'h1, 1'b0, 8'h5A);
        send(CMD_RD, 2'h2, 2'h1, 1'b1, 8'h00);
        poll(REG_RDATA, RDATA_VALID_BIT, 1'b1);
        cmp(q, 32'h0000015A);
        send(CMD_WR, 2'h1, 2'h0, 1'b0, 8'hC3);
        send(CMD_RD, 2'h2, 2'h1, 1'b1, 8'h00);
        poll(REG_RDATA, RDATA_VALID_BIT, 1'b1);
        cmp(q, 32'h0000015A);
        send(CMD_ACT, 2'h0, 2'h0, 1'b0, 8'h00);
        send(CMD_ACT, 2'h1, 2'h0, 1'b0, 8'h00);
        send(CMD_ACT, 2'h1, 2'h2, 1'b0, 8'h00);
        cmp({31'h0, calFault}, 32'h0);
        $display("test traffic done");
        // every burst mode with both select levels
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 2; s++) begin
                modeCfg <= 2'(m);
                wb(1'b1, REG_CFG, 32'(m));
                rdExp = (m == 0 || (m == 1 && s == 1)) ? 4'h8 : 4'h4;
                wrExp = (m == 2) ? 4'h4 : 4'h8;
                send(CMD_RD, 2'h0, 2'h3, 1'(s), 8'h00);
                poll(REG_RDATA, RDATA_VALID_BIT, 1'b1);
                cmp({28'h0, burstLen}, {28'h0, rdExp});
                send(CMD_WR, 2'h3, 2'h0, 1'(s), 8'(m));
                cmp({28'h0, burstLen}, {28'h0, wrExp});
            end
        end
        $display("test burst modes done");
        cmp({31'h0, lockFault}, 32'h0);
        dllLocked <= 1'b0;
        repeat (4) @(posedge sys_clk);
        send(CMD_RD, 2'h2, 2'h1, 1'b1, 8'h00);
        poll(REG_RDATA, RDATA_VALID_BIT, 1'b1);
        cmp({31'h0, lockFault}, 32'h1);
        $display("test lock done");
        summarize();
    end
endmodule
